// [hdl/audio_clock_config_regs.sv]
// Function
// - With the override bit set, the rate selection comes from the register field, not the pins.
// - The register rate field resets to 011b, meaning 48 kHz.
// - Two read/write 6-bit fields in bits 5..0 set the audio loop bandwidth.
// - Both loop values default to figures that depend on the selected sampling rate.
// - A 3-bit field picks the first audio clock multiple, resetting to zero.
// - With extra multiples on, a 512 fs output runs at about one third duty.
// - Under override the rate pins are ignored, yet the board must still drive them.
`timescale 1ns/1ps
`default_nettype none
module audio_clock_config_regs
    import audio_clock_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic [RATE_W-1:0] audio_rate_select_pins,
    output logic      [RATE_W-1:0] effective_rate,
    output logic      [GAIN_W-1:0] loop_gain_a,
    output logic      [GAIN_W-1:0] loop_gain_b,
    output logic                   extra_multiples_enable,
    output logic                   audio_clock_out_first,
    output logic                   audio_clock_oe_n
);

    // bus state
    ahb_req_t req_reg;
    ahb_req_t req_next;

    // software-visible storage
    logic              override_en_reg;
    logic              override_en_next;
    logic              extra_en_reg;
    logic              extra_en_next;
    logic [RATE_W-1:0] rate_override_reg;
    logic [RATE_W-1:0] rate_override_next;
    logic [GAIN_W-1:0] gain_a_reg;
    logic [GAIN_W-1:0] gain_a_next;
    logic [GAIN_W-1:0] gain_b_reg;
    logic [GAIN_W-1:0] gain_b_next;
    logic              gain_a_set_reg;
    logic              gain_a_set_next;
    logic              gain_b_set_reg;
    logic              gain_b_set_next;
    logic [MULT_W-1:0] first_mult_reg;
    logic [MULT_W-1:0] first_mult_next;

    // derived values
    logic [RATE_W-1:0] rate_sel;
    logic [RATE_W-1:0] rate_sel_next;
    logic [GAIN_W-1:0] gain_a_view;
    logic [GAIN_W-1:0] gain_b_view;
    logic [GAIN_W-1:0] gain_a_view_next;
    logic [GAIN_W-1:0] gain_b_view_next;
    logic [31:0]       rdata_next;

    // address-phase decode
    wire        addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire        word_size  = (hsize == HSIZE_WORD);
    wire [7:0]  addr_idx   = haddr[9:2];
    wire        addr_hi_ok = (haddr[31:10] == 22'h000000);

    // data-phase write strobes
    wire        wr_active  = req_reg.valid && req_reg.write;
    wire        wr_ctrl    = wr_active && (req_reg.idx == IDX_AUDIO_CONTROL);
    wire        wr_rate    = wr_active && (req_reg.idx == IDX_AUDIO_RATE_OVERRIDE);
    wire        wr_gain_a  = wr_active && (req_reg.idx == IDX_AUDIO_LOOP_GAIN_A);
    wire        wr_gain_b  = wr_active && (req_reg.idx == IDX_AUDIO_LOOP_GAIN_B);
    wire        wr_mult    = wr_active && (req_reg.idx == IDX_FIRST_CLOCK_MULT);

    // read select on the address phase
    wire        rd_take    = addr_phase && !hwrite;
    wire        rd_ctrl    = (addr_idx == IDX_AUDIO_CONTROL);
    wire        rd_rate    = (addr_idx == IDX_AUDIO_RATE_OVERRIDE);
    wire        rd_gain_a  = (addr_idx == IDX_AUDIO_LOOP_GAIN_A);
    wire        rd_gain_b  = (addr_idx == IDX_AUDIO_LOOP_GAIN_B);
    wire        rd_mult    = (addr_idx == IDX_FIRST_CLOCK_MULT);

    // only whole-word transfers inside the decoded window are recorded
    assign req_next.valid = addr_phase && word_size && addr_hi_ok;
    assign req_next.write = hwrite;
    assign req_next.idx   = addr_idx;

    // reserved bits are dropped on write, so they always read back as zero
    assign override_en_next   = wr_ctrl ? hwdata[CTRL_OVERRIDE_BIT] : override_en_reg;
    assign extra_en_next      = wr_ctrl ? hwdata[CTRL_EXTRA_BIT] : extra_en_reg;
    assign rate_override_next = wr_rate ? hwdata[RATE_W-1:0] : rate_override_reg;
    assign gain_a_next        = wr_gain_a ? hwdata[GAIN_W-1:0] : gain_a_reg;
    assign gain_b_next        = wr_gain_b ? hwdata[GAIN_W-1:0] : gain_b_reg;
    assign gain_a_set_next    = gain_a_set_reg || wr_gain_a;
    assign gain_b_set_next    = gain_b_set_reg || wr_gain_b;
    assign first_mult_next    = wr_mult ? hwdata[MULT_W-1:0] : first_mult_reg;

    rate_pin_sync u_rate_sync (
        .clk          (hclk),
        .rst_n        (hresetn),
        .pins         (audio_rate_select_pins),
        .override_en  (override_en_reg),
        .override_val (rate_override_reg),
        .rate_sel     (rate_sel)
    );

    // a write in its data phase lands before a following read samples it
    assign rate_sel_next = override_en_next ? rate_override_next : rate_sel;

    assign gain_a_view      = gain_a_set_reg ? gain_a_reg : default_gain_a(rate_sel);
    assign gain_b_view      = gain_b_set_reg ? gain_b_reg : default_gain_b(rate_sel);
    assign gain_a_view_next = gain_a_set_next ? gain_a_next : default_gain_a(rate_sel_next);
    assign gain_b_view_next = gain_b_set_next ? gain_b_next : default_gain_b(rate_sel_next);

    // read mux sees next values so back-to-back write then read is coherent
    always_comb begin
        rdata_next = 32'h00000000;
        if (rd_take && word_size && addr_hi_ok) begin
            if (rd_ctrl) begin
                rdata_next[CTRL_OVERRIDE_BIT] = override_en_next;
                rdata_next[CTRL_EXTRA_BIT]    = extra_en_next;
            end else if (rd_rate) begin
                rdata_next[RATE_W-1:0] = rate_override_next;
            end else if (rd_gain_a) begin
                rdata_next[GAIN_W-1:0] = gain_a_view_next;
            end else if (rd_gain_b) begin
                rdata_next[GAIN_W-1:0] = gain_b_view_next;
            end else if (rd_mult) begin
                rdata_next[MULT_W-1:0] = first_mult_next;
            end else begin
                rdata_next = 32'h00000000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_reg   <= '0;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            req_reg   <= req_next;
            hrdata    <= rdata_next;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            override_en_reg   <= CTRL_RESET;
            extra_en_reg      <= CTRL_RESET;
            rate_override_reg <= RATE_RESET;
        end else begin
            override_en_reg   <= override_en_next;
            extra_en_reg      <= extra_en_next;
            rate_override_reg <= rate_override_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gain_a_reg     <= '0;
            gain_b_reg     <= '0;
            gain_a_set_reg <= 1'b0;
            gain_b_set_reg <= 1'b0;
        end else begin
            gain_a_reg     <= gain_a_next;
            gain_b_reg     <= gain_b_next;
            gain_a_set_reg <= gain_a_set_next;
            gain_b_set_reg <= gain_b_set_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_mult_reg <= MULT_RESET;
        end else begin
            first_mult_reg <= first_mult_next;
        end
    end

    // loop values go out in the same cycle as the rate they track
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            effective_rate         <= RATE_RESET;
            loop_gain_a            <= default_gain_a(RATE_RESET);
            loop_gain_b            <= default_gain_b(RATE_RESET);
            extra_multiples_enable <= CTRL_RESET;
        end else begin
            effective_rate         <= rate_sel;
            loop_gain_a            <= gain_a_view;
            loop_gain_b            <= gain_b_view;
            extra_multiples_enable <= extra_en_reg;
        end
    end

    // base tick is hclk; a real part would feed this from the audio synthesiser
    audio_clock_gen u_clock_first (
        .clk       (hclk),
        .rst_n     (hresetn),
        .mult_code (first_mult_reg),
        .extra_en  (extra_en_reg),
        .clk_out   (audio_clock_out_first),
        .oe_n      (audio_clock_oe_n)
    );

endmodule : audio_clock_config_regs
`default_nettype wire

// [hdl/audio_clock_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module audio_clock_gen
    import audio_clock_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [MULT_W-1:0] mult_code,
    input  wire logic              extra_en,
    output logic                   clk_out,
    output logic                   oe_n
);

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_now;
    logic [DIV_W-1:0] high_len;
    logic             wrap;
    logic             restart;

    assign div_now  = clock_divisor(mult_code, extra_en);
    assign high_len = div_now >> 1;
    assign restart  = (div_now != div_reg);
    assign wrap     = (cnt_reg >= div_now - 11'h001);
    assign cnt_next = (restart || wrap || div_now == 11'h000) ? 11'h000 : cnt_reg + 11'h001;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            div_reg <= '0;
            clk_out <= 1'b0;
            oe_n    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            div_reg <= div_now;
            clk_out <= (div_now != 11'h000) && (cnt_next < high_len);
            oe_n    <= (mult_code == MULT_ZBIT);
        end
    end

endmodule : audio_clock_gen
`default_nettype wire

// [hdl/audio_clock_pkg.sv]
package audio_clock_pkg;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_AUDIO_CONTROL       = 8'h31;
    localparam logic [7:0] IDX_AUDIO_RATE_OVERRIDE = 8'h32;
    localparam logic [7:0] IDX_AUDIO_LOOP_GAIN_A   = 8'h39;
    localparam logic [7:0] IDX_AUDIO_LOOP_GAIN_B   = 8'h3A;
    localparam logic [7:0] IDX_FIRST_CLOCK_MULT    = 8'h3F;

    localparam int RATE_W = 3;
    localparam int GAIN_W = 6;
    localparam int MULT_W = 3;
    localparam int DIV_W  = 11;

    // field positions
    localparam int CTRL_OVERRIDE_BIT = 2;
    localparam int CTRL_EXTRA_BIT    = 5;

    // reset values
    localparam logic [RATE_W-1:0] RATE_RESET  = 3'h3;
    localparam logic [MULT_W-1:0] MULT_RESET  = 3'h0;
    localparam logic              CTRL_RESET  = 1'h0;

    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef enum logic [MULT_W-1:0] {
        MULT_512FS = 3'b000,
        MULT_384FS = 3'b001,
        MULT_256FS = 3'b010,
        MULT_192FS = 3'b011,
        MULT_128FS = 3'b100,
        MULT_64FS  = 3'b101,
        MULT_1FS   = 3'b110,
        MULT_ZBIT  = 3'b111
    } mult_code_t;

    // data-phase record of an accepted transfer
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] idx;
    } ahb_req_t;

    // loop gain defaults per selected rate code
    function automatic logic [GAIN_W-1:0] default_gain_a(input logic [RATE_W-1:0] rate);
        case (rate)
            3'h0:    default_gain_a = 6'h0A;
            3'h1:    default_gain_a = 6'h0C;
            3'h2:    default_gain_a = 6'h0E;
            3'h3:    default_gain_a = 6'h10;
            default: default_gain_a = 6'h0A;
        endcase
    endfunction : default_gain_a

    function automatic logic [GAIN_W-1:0] default_gain_b(input logic [RATE_W-1:0] rate);
        case (rate)
            3'h0:    default_gain_b = 6'h20;
            3'h1:    default_gain_b = 6'h22;
            3'h2:    default_gain_b = 6'h24;
            3'h3:    default_gain_b = 6'h26;
            default: default_gain_b = 6'h2A;
        endcase
    endfunction : default_gain_b

    // output period in base ticks; zero means no toggling
    function automatic logic [DIV_W-1:0] clock_divisor(input logic [MULT_W-1:0] code,
                                                       input logic              extra);
        case (code)
            MULT_512FS: clock_divisor = extra ? 11'h003 : 11'h002;
            MULT_384FS: clock_divisor = extra ? 11'h004 : 11'h000;
            MULT_256FS: clock_divisor = extra ? 11'h006 : 11'h004;
            MULT_192FS: clock_divisor = extra ? 11'h008 : 11'h000;
            MULT_128FS: clock_divisor = extra ? 11'h00C : 11'h008;
            MULT_64FS:  clock_divisor = extra ? 11'h018 : 11'h010;
            MULT_1FS:   clock_divisor = extra ? 11'h600 : 11'h400;
            default:    clock_divisor = 11'h000;
        endcase
    endfunction : clock_divisor

endpackage : audio_clock_pkg

// [hdl/rate_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module rate_pin_sync
    import audio_clock_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [RATE_W-1:0] pins,
    input  wire logic              override_en,
    input  wire logic [RATE_W-1:0] override_val,
    output logic      [RATE_W-1:0] rate_sel
);

    logic [RATE_W-1:0] meta_reg;
    logic [RATE_W-1:0] sync_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RATE_RESET;
            sync_reg <= RATE_RESET;
        end else begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
        end
    end

    assign rate_sel = override_en ? override_val : sync_reg;

endmodule : rate_pin_sync
`default_nettype wire

// [testbench/audio_clock_config_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module audio_clock_config_regs_sva
    import audio_clock_pkg::*;
(
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [2:0]        hsize,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic [RATE_W-1:0] audio_rate_select_pins,
    input wire logic [RATE_W-1:0] effective_rate,
    input wire logic [GAIN_W-1:0] loop_gain_a,
    input wire logic [GAIN_W-1:0] loop_gain_b,
    input wire logic              extra_multiples_enable,
    input wire logic              audio_clock_out_first,
    input wire logic              audio_clock_oe_n
);
    wire logic take    = hsel && hready && htrans == HTRANS_NONSEQ;
    wire logic ctrl_wr = take && hwrite && haddr == 32'h0000_00C4;
    wire logic rd_take = take && !hwrite;
    wire logic mult_wr = take && hwrite && haddr == 32'h0000_00FC;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_READY_OKAY: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or flagged an error");
    AST_IDLE_RDATA: assert property (!$past(rd_take) |-> hrdata == 32'h0)
        else $error("read data not zero outside a read");
    AST_RESET_RATE: assert property ($rose(hresetn) |-> effective_rate == 3'h3)
        else $error("rate code after reset is not 48 kHz");
    AST_RESET_GAIN: assert property ($rose(hresetn) |-> loop_gain_a == 6'h10 && loop_gain_b == 6'h26)
        else $error("loop values after reset not the rate defaults");
    AST_RESET_CLOCK: assert property ($rose(hresetn) |-> !audio_clock_out_first && !audio_clock_oe_n)
        else $error("audio clock not idle and driven after reset");
    AST_ZBIT_QUIET: assert property (audio_clock_oe_n |-> !audio_clock_out_first)
        else $error("audio clock toggles while released");
    AST_EXTRA_FROM_WRITE: assert property ($changed(extra_multiples_enable) |-> $past(ctrl_wr, 2) || $past(ctrl_wr, 3) || $past(ctrl_wr, 4))
        else $error("extra multiples bit moved without a control write");
    // a single high cycle under extra multiples must be followed by two low ones;
    // a new multiple restarts the divider, so cycles near such a write are left out
    AST_DUTY_THIRD: assert property (extra_multiples_enable && !audio_clock_oe_n && $fell(audio_clock_out_first) && !$past(audio_clock_out_first, 2) && !$past(mult_wr, 1) && !$past(mult_wr, 2) && !$past(mult_wr, 3) && !$past(mult_wr, 4) |=> !audio_clock_out_first ##1 audio_clock_out_first)
        else $error("one third duty pattern broken");
endmodule : audio_clock_config_regs_sva

bind audio_clock_config_regs audio_clock_config_regs_sva chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .audio_rate_select_pins(audio_rate_select_pins),
    .effective_rate(effective_rate), .loop_gain_a(loop_gain_a), .loop_gain_b(loop_gain_b),
    .extra_multiples_enable(extra_multiples_enable),
    .audio_clock_out_first(audio_clock_out_first), .audio_clock_oe_n(audio_clock_oe_n)
);
`default_nettype wire

// [testbench/audio_clock_config_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module audio_clock_config_regs_tb_top;
    import audio_clock_pkg::*;
    logic              hclk     = 1'b0;
    logic              hresetn  = 1'b0;
    logic              hsel     = 1'b0;
    logic [31:0]       haddr    = 32'h0;
    logic [1:0]        htrans   = 2'h0;
    logic              hwrite   = 1'b0;
    logic [2:0]        hsize    = HSIZE_WORD;
    logic [31:0]       hwdata   = 32'h0;
    logic [RATE_W-1:0] pins     = 3'h3;
    logic [31:0]       rd_hold;
    logic [2:0]        bus_size = HSIZE_WORD;
    wire logic [31:0]       hrdata;
    wire logic              hreadyout, hresp, extra, clk_out, oe_n;
    wire logic [RATE_W-1:0] effective_rate;
    wire logic [GAIN_W-1:0] gain_a, gain_b;
    int                errors      = 0;
    int                check_count = 0;

    always #50 hclk = ~hclk;
    // data phase value, captured away from the edge that ends it
    always @(negedge hclk) rd_hold = hrdata;

    audio_clock_config_regs dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .audio_rate_select_pins(pins), .effective_rate(effective_rate),
        .loop_gain_a(gain_a), .loop_gain_b(gain_b), .extra_multiples_enable(extra),
        .audio_clock_out_first(clk_out), .audio_clock_oe_n(oe_n)
    );

    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= w; hsize <= bus_size;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = rd_hold;
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        `CHK(nm, exp, r)
    endtask : rd_chk

    task automatic settle(input int n);
        repeat (n) @(negedge hclk);
    endtask : settle

    task automatic set_pins(input logic [RATE_W-1:0] v);
        @(posedge hclk);
        pins <= v;
        settle(5);
    endtask : set_pins

    task automatic t_reset;
        rd_chk("control", 32'hC4, 32'h0);
        rd_chk("rate_field", 32'hC8, 32'h3);
        rd_chk("gain_a", 32'hE4, 32'h10);
        rd_chk("gain_b", 32'hE8, 32'h26);
        rd_chk("multiple", 32'hFC, 32'h0);
        wr(32'h100, 32'h5);
        rd_chk("unmapped", 32'h100, 32'h0);
        // non-word transfers and addresses above the window are dropped
        bus_size = 3'h0;
        wr(32'hFC, 32'h3);
        bus_size = HSIZE_WORD;
        rd_chk("byte_dropped", 32'hFC, 32'h0);
        wr(32'h4C8, 32'h5);
        rd_chk("alias_dropped", 32'hC8, 32'h3);
        settle(1);
        `CHK("rate_out", 3'h3, effective_rate)
    endtask : t_reset

    task automatic t_override;
        set_pins(3'h5);
        `CHK("rate_pins", 3'h5, effective_rate)
        `CHK("gain_a_def", 6'h0A, gain_a)
        wr(32'hC8, 32'h1);
        settle(4);
        `CHK("rate_no_ovr", 3'h5, effective_rate)
        wr(32'hC4, 32'h4);
        settle(4);
        `CHK("rate_ovr", 3'h1, effective_rate)
        `CHK("gain_b_def", 6'h22, gain_b)
        set_pins(3'h2);
        `CHK("pins_ignored", 3'h1, effective_rate)
        wr(32'hC4, 32'h0);
        settle(4);
        `CHK("rate_back", 3'h2, effective_rate)
    endtask : t_override

    task automatic t_gains;
        wr(32'hE8, 32'h2A);
        wr(32'hE4, 32'h15);
        rd_chk("gain_a_rw", 32'hE4, 32'h15);
        rd_chk("gain_b_rw", 32'hE8, 32'h2A);
        set_pins(3'h0);
        `CHK("gain_a_kept", 6'h15, gain_a)
        `CHK("gain_b_kept", 6'h2A, gain_b)
        // lowest legal pair: software keeps first value at or below second minus 21
        wr(32'hE4, 32'hA);
        wr(32'hE8, 32'h20);
        settle(4);
        `CHK("gain_a_min", 6'h0A, gain_a)
        `CHK("gain_b_min", 6'h20, gain_b)
    endtask : t_gains

    // high time and period of one whole output cycle; zero when it never toggles
    task automatic meas(output int hi, output int per);
        int n;
        n = 0; hi = 0; per = 0;
        do begin @(negedge hclk); n++; end while (clk_out !== 1'b0 && n < 3200);
        do begin @(negedge hclk); n++; end while (clk_out !== 1'b1 && n < 3200);
        if (n < 3200) begin
            do begin @(negedge hclk); hi++; end while (clk_out === 1'b1 && hi < 3200);
            per = hi;
            do begin @(negedge hclk); per++; end while (clk_out === 1'b0 && per < 3200);
        end
    endtask : meas

    task automatic t_multiples;
        int p[2][8] = '{'{2, 0, 4, 0, 8, 16, 1024, 0}, '{3, 4, 6, 8, 12, 24, 1536, 0}};
        int hi, per;
        for (int x = 0; x < 2; x++) begin
            wr(32'hC4, (x == 1) ? 32'h20 : 32'h0);
            for (int c = 0; c < 8; c++) begin
                wr(32'hFC, c);
                rd_chk("mult_rw", 32'hFC, c);
                settle(3);
                `CHK("oe_n", (c == 7), oe_n)
                `CHK("extra", (x == 1), extra)
                meas(hi, per);
                `CHK("period", p[x][c], per)
                `CHK("high_time", p[x][c] / 2, hi)
            end
        end
    endtask : t_multiples

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // longest pass is a non-toggling multiple's 3200-cycle timeout, well under this span
    initial begin
        repeat (60000) @(posedge hclk);
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_override();
        t_gains();
        t_multiples();
        report_and_stop();
    end
endmodule : audio_clock_config_regs_tb_top
`default_nettype wire
